//--- sim/ppfl_pin_model.sv
// Pin side model: resolves each pad level from all drivers on it.
`timescale 1ns/10ps
module ppfl_pin_model
(
  input  wire logic            core_clk_i, // Core clock.
  input  wire logic [4:0][7:0] out_i,      // Device output levels.
  input  wire logic [4:0][7:0] oe_i,       // Device output enables.
  input  wire logic [4:0][7:0] pu_i,       // Device pull-up connects.
  input  wire logic [4:0][7:0] ext_val_i,  // External driver levels.
  input  wire logic [4:0][7:0] ext_en_i,   // External driver enables.
  output logic      [4:0][7:0] level_o     // Resolved pad levels.
);
  logic [7:0] float_ff; // Pattern shown by an undriven pad.

  // A floating pad changes every cycle so no stale value can pass.
  always_ff @(posedge core_clk_i)
  begin
    float_ff <= (float_ff === 8'h55) ? 8'haa : 8'h55;
  end

  // Device buffer first, then external driver, then pull-up.
  // An output pin shows its device level even when its pull-up is selected.
  always_comb
  begin
    for (int p = 0; p < 5; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (oe_i[p][b])
          level_o[p][b] = out_i[p][b];
        else if (ext_en_i[p][b])
          level_o[p][b] = ext_val_i[p][b];
        else if (pu_i[p][b])
          level_o[p][b] = 1'b1;
        else
          level_o[p][b] = float_ff[b];
      end
    end
  end
endmodule : ppfl_pin_model

//--- sim/testbench.sv
// Self-checking bench for the port pull-up, function and latch block.
`timescale 1ns/10ps
module testbench;
  import ppfl_pkg::*;
  typedef struct packed
  {
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } ppfl_row_t; // Address, write data, expected read.

  logic            core_clk_i = 1'b0;
  logic            rst_n_i    = 1'b0;
  logic     [15:0] addr       = '0;
  logic      [7:0] wdata      = '0;
  logic            wr         = 1'b0;
  logic            rd         = 1'b0;
  logic      [7:0] rdata;
  logic [4:0][7:0] pin, pout, poe, pu;
  logic [4:0][7:0] ext_val    = '0;
  logic [4:0][7:0] ext_en     = '0;
  logic      [5:0] lcd        = '0;
  int              error_cnt  = 0;
  int              tests_run  = 0;
  ppfl_row_t       rows [6];

  always #4 core_clk_i = ~core_clk_i;

  ppfl_port_ctrl ppfl_port_ctrl_i (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_rdata_o(rdata), .pin_i(pin),
    .pin_out_o(pout), .pin_oe_o(poe), .pu_en_o(pu),
    .lcd_segment_output_i(lcd));

  ppfl_pin_model ppfl_pin_model_i (.core_clk_i(core_clk_i),
    .out_i(pout), .oe_i(poe), .pu_i(pu), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .level_o(pin));

  // Compares one observed byte against its expectation.
  task automatic chk(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One write cycle; the write edge lands before the next falling edge.
  task automatic wrb(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge core_clk_i);
    wr = 1'b0;
  endtask : wrb

  // One read cycle; data is valid one edge after the strobe.
  task automatic rdb(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge core_clk_i);
    rd = 1'b0;
    d = rdata;
  endtask : rdb

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Cuts a hung run short.
  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    logic [7:0] v;
    // Pull-up and function rows keep the spare register bits at zero.
    rows = '{'{16'hfff7, 8'h13, 8'h13}, '{16'hff32, 8'h05, 8'h05},
             '{16'hff58, 8'h2a, 8'h2a}, '{16'hff10, 8'h55, 8'h00},
             '{16'hff21, 8'hfc, 8'hfc}, '{16'hff20, 8'hfe, 8'hfe}};
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    rdb(PPFL_ADDR_GRPU, v); chk("grp rst", v, 8'h00);
    rdb(PPFL_ADDR_P2PU, v); chk("p2pu rst", v, 8'h00);
    rdb(PPFL_ADDR_P8FN, v); chk("p8fn rst", v, 8'h00);
    chk("oe0 rst", poe[0], 8'h00);
    // Register writes and read-back, including an unmapped address.
    foreach (rows[i])
    begin
      wrb(rows[i].a, rows[i].d);
      rdb(rows[i].a, v);
      chk("row read", v, rows[i].e);
    end
    chk("pull p0 in", pu[0], 8'h0e);
    chk("pu1 out", pu[1], 8'h00);
    chk("pu2 in", pu[2], 8'h05);
    wrb(16'hff22, 8'hf8);
    chk("pu2 out", pu[2], 8'h05);
    // Output pins of port 2 keep their pull-up, so clear it.
    wrb(PPFL_ADDR_P2PU, 8'h00);
    chk("pu2 clr", pu[2], 8'h00);
    // Port 2 output write, drive and latch read-back.
    wrb(16'hff02, 8'h06);
    chk("p2 out", pout[2], 8'h06);
    chk("oe2 out", poe[2], 8'h07);
    rdb(16'hff02, v);  chk("p2 rd", v, 8'h06);
    // Input mode write keeps the pad; pull-ups set the read level.
    wrb(16'hff04, 8'h05);
    chk("oe4 in", poe[3], 8'h00);
    rdb(16'hff04, v);  chk("p4 in rd", v & 8'h0f, 8'h0f);
    wrb(16'hff24, 8'hf0);
    chk("pu4 out", pu[3], 8'h00);
    chk("p4 kept", pout[3] & 8'h0f, 8'h05);
    chk("oe4 out", poe[3], 8'h0f);
    // Output mode write, read-back and read-modify-write.
    wrb(16'hff01, 8'h02);
    chk("p1 out", pout[1], 8'h02);
    chk("oe1 out", poe[1], 8'h03);
    rdb(16'hff01, v);  chk("p1 rd", v & 8'h03, 8'h02);
    wrb(16'hff01, (v & 8'h03) + 8'h01);
    chk("p1 rmw", pout[1], 8'h03);
    // Mixed port 0: output bit reads latch, input bits read the pad.
    ext_val[0] = 8'h04;
    ext_en[0] = 8'h0e;
    wrb(16'hff00, 8'h0a);
    rdb(16'hff00, v);  chk("p0 mix", v & 8'h0f, 8'h04);
    // External drivers let go before the device drives every bit.
    ext_en[0] = 8'h00;
    wrb(16'hff20, 8'hf0);
    chk("p0 byte", pout[0], 8'h0a);
    // Port 8 segment select per bit.
    lcd = 6'h0a;
    wrb(16'hff08, 8'h3f);
    chk("p8 out", pout[4], 8'h1f);
    chk("oe8", poe[4], 8'h2a);
    // Reset in mid-run clears the latches and control registers and sets every pin to input.
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    chk("oe1 rst", poe[1], 8'h00);
    chk("pull p0 rst", pu[0], 8'h00);
    rst_n_i = 1'b1;
    rdb(PPFL_ADDR_GRPU, v); chk("grp rst2", v, 8'h00);
    rdb(PPFL_ADDR_P8FN, v); chk("p8fn rst2", v, 8'h00);
    finish_test();
  end
endmodule : testbench

//--- verilog/ppfl_pin_cell.sv
// One port: output latch, direction register, pull-up gating and read mux.
`timescale 1ns/10ps
module ppfl_pin_cell
#(
  parameter logic [7:0] PIN_MASK = 8'hff,  // Implemented pins.
  parameter logic [7:0] MODE_RST = 8'hff   // Direction reset value.
)
(
  input  wire logic       core_clk_i,    // Core clock.
  input  wire logic       rst_n_i,       // Asynchronous reset, active low.
  input  wire logic       wr_latch_i,    // Write strobe for the latch.
  input  wire logic       wr_mode_i,     // Write strobe for direction.
  input  wire logic [7:0] wdata_i,       // Write data.
  input  wire logic [7:0] pin_i,         // Sampled pin levels.
  input  wire logic [7:0] pu_sel_i,      // Pull-up select per pin.
  input  wire logic       pu_any_mode_i, // Pull-up also in output mode.
  output logic      [7:0] latch_o,       // Output latch contents.
  output logic      [7:0] mode_o,        // Direction bits, one is input.
  output logic      [7:0] mode_rd_o,     // Direction register read value.
  output logic      [7:0] oe_o,          // Output buffer enable.
  output logic      [7:0] pu_o,          // Pull-up connect per pin.
  output logic      [7:0] rd_o           // Port read value.
);

  import ppfl_pkg::*;

  logic [7:0] latch_ff;      // Output latch.
  logic [7:0] nxt_latch;     // Next latch value.
  logic [7:0] mode_ff;       // Direction bits.
  logic [7:0] nxt_mode;      // Next direction bits.

  // Whole-byte writes: bits in input mode take the written byte too.
  always_comb
  begin
    nxt_latch = latch_ff;
    nxt_mode  = mode_ff;
    if (wr_latch_i)
    begin
      nxt_latch = wdata_i & PIN_MASK;
    end
    if (wr_mode_i)
    begin
      nxt_mode = wdata_i & PIN_MASK;
    end
  end

  // Registers both; writes land on the edge ending the bus cycle.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latch_ff <= PPFL_REG_RST;
      mode_ff  <= MODE_RST & PIN_MASK;
    end
    else
    begin
      latch_ff <= nxt_latch;
      mode_ff  <= nxt_mode;
    end
  end

  // Output buffer is on only for output-mode bits.
  always_comb
  begin
    latch_o   = latch_ff;
    mode_o    = mode_ff;
    mode_rd_o = mode_ff | (MODE_RST & ~PIN_MASK);
    oe_o      = ~mode_ff & PIN_MASK;
    // Output bits get no pull-up unless this port allows it in any mode.
    pu_o      = pu_sel_i & PIN_MASK &
                (pu_any_mode_i ? 8'hff : mode_ff);
    // Output mode reads the latch, input mode reads the pin.
    rd_o      = ((latch_ff & ~mode_ff) |
                 (pin_i & mode_ff)) & PIN_MASK;
  end

endmodule : ppfl_pin_cell

//--- verilog/ppfl_pkg.sv
// Constants shared by the port pull-up, function and latch block.
package ppfl_pkg;

  // Number of ports handled here: ports 0, 1, 2, 4 and 8, in that order.
  localparam int          PPFL_NPORT     = 5;
  // Index of each port in the packed port arrays.
  localparam int          PPFL_IX_P0     = 0;
  localparam int          PPFL_IX_P1     = 1;
  localparam int          PPFL_IX_P2     = 2;
  localparam int          PPFL_IX_P4     = 3;
  localparam int          PPFL_IX_P8     = 4;

  // Addresses of the three pull-up and function registers.
  localparam logic [15:0] PPFL_ADDR_P2PU = 16'hff32;
  localparam logic [15:0] PPFL_ADDR_P8FN = 16'hff58;
  localparam logic [15:0] PPFL_ADDR_GRPU = 16'hfff7;

  // Output latch addresses, one per port, highest index first.
  localparam logic [4:0][15:0] PPFL_LATCH_ADDR =
    {16'hff08, 16'hff04, 16'hff02, 16'hff01, 16'hff00};
  // Direction register addresses, one per port.
  localparam logic [4:0][15:0] PPFL_MODE_ADDR =
    {16'hff28, 16'hff24, 16'hff22, 16'hff21, 16'hff20};
  // Implemented pins of each port.
  localparam logic [4:0][7:0] PPFL_PIN_MASK =
    {8'h3f, 8'h0f, 8'h07, 8'h03, 8'h0f};
  // Direction register value after reset; a one is input mode.
  localparam logic [4:0][7:0] PPFL_MODE_RST =
    {8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};

  // Implemented bits of the pull-up and function registers.
  localparam logic [7:0]  PPFL_GRPU_MASK = 8'h13;
  localparam logic [7:0]  PPFL_P2PU_MASK = 8'h07;
  localparam logic [7:0]  PPFL_P8FN_MASK = 8'h3f;
  // Bit positions inside the grouped pull-up register.
  localparam int          PPFL_GRPU_B_P0 = 0;
  localparam int          PPFL_GRPU_B_P1 = 1;
  localparam int          PPFL_GRPU_B_P4 = 4;

  // Reset value of the latches and the pull-up and function registers.
  localparam logic [7:0]  PPFL_REG_RST   = 8'h00;

endpackage : ppfl_pkg

//--- verilog/ppfl_port_ctrl.sv
// Port pull-up, port 8 function select and output latch control.
`timescale 1ns/10ps
module ppfl_port_ctrl
(
  input  wire logic            core_clk_i,  // Core clock, 125 MHz.
  input  wire logic            rst_n_i,     // Asynchronous reset, low.
  input  wire logic     [15:0] cpu_addr_i,  // CPU bus address.
  input  wire logic      [7:0] cpu_wdata_i, // CPU bus write data.
  input  wire logic            cpu_wr_i,    // CPU write strobe.
  input  wire logic            cpu_rd_i,    // CPU read strobe.
  output logic           [7:0] cpu_rdata_o, // Read data, one cycle later.
  input  wire logic [4:0][7:0] pin_i,       // Sampled pin levels.
  output logic      [4:0][7:0] pin_out_o,   // Pin output levels.
  output logic      [4:0][7:0] pin_oe_o,    // Pin output enables.
  output logic      [4:0][7:0] pu_en_o,     // Pull-up connect per pin.
  input  wire logic      [5:0] lcd_segment_output_i // Segment drive.
);

  import ppfl_pkg::*;

  logic [7:0] grouped_port_pullup_select_ff;  // Grouped pull-up register.
  logic [7:0] nxt_grouped_port_pullup_select; // Its next value.
  logic [7:0] port2_pin_pullup_select_ff;     // Port 2 pull-up register.
  logic [7:0] nxt_port2_pin_pullup_select;    // Its next value.
  logic [7:0] port8_pin_function_select_ff;   // Port 8 function register.
  logic [7:0] nxt_port8_pin_function_select;  // Its next value.
  logic [7:0] rdata_ff;                       // Registered read data.
  logic [7:0] nxt_rdata;                      // Its next value.

  logic [4:0][7:0] lat;     // Latch contents per port.
  logic [4:0][7:0] mode;    // Direction bits per port.
  logic [4:0][7:0] mode_rd; // Direction read values per port.
  logic [4:0][7:0] oe;      // Output buffer enables per port.
  logic [4:0][7:0] prd;     // Port read values per port.
  logic [4:0][7:0] pu_sel;  // Pull-up selects per port.
  logic [4:0]      pu_any;  // Pull-up allowed in output mode.
  logic [7:0]      seg_sel; // Port 8 segment selection, masked.
  logic [7:0]      seg_val; // Segment levels, widened.

  // Pull-up select per port from the two pull-up registers.
  always_comb
  begin
    pu_sel = '0;
    pu_any = '0;
    pu_sel[PPFL_IX_P0] =
      {8{grouped_port_pullup_select_ff[PPFL_GRPU_B_P0]}};
    pu_sel[PPFL_IX_P1] =
      {8{grouped_port_pullup_select_ff[PPFL_GRPU_B_P1]}};
    pu_sel[PPFL_IX_P4] =
      {8{grouped_port_pullup_select_ff[PPFL_GRPU_B_P4]}};
    pu_sel[PPFL_IX_P2] = port2_pin_pullup_select_ff;
    pu_any[PPFL_IX_P2] = 1'b1;
  end

  // One latch, direction register and read mux per port.
  generate
    for (genvar gi = 0; gi < PPFL_NPORT; gi++)
    begin : g_port
      ppfl_pin_cell #(
        .PIN_MASK (PPFL_PIN_MASK[gi]),
        .MODE_RST (PPFL_MODE_RST[gi])
      ) u_cell (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_latch_i    (cpu_wr_i &&
                        cpu_addr_i == PPFL_LATCH_ADDR[gi]),
        .wr_mode_i     (cpu_wr_i && cpu_addr_i == PPFL_MODE_ADDR[gi]),
        .wdata_i       (cpu_wdata_i),
        .pin_i         (pin_i[gi]),
        .pu_sel_i      (pu_sel[gi]),
        .pu_any_mode_i (pu_any[gi]),
        .latch_o       (lat[gi]),
        .mode_o        (mode[gi]),
        .mode_rd_o     (mode_rd[gi]),
        .oe_o          (oe[gi]),
        .pu_o          (pu_en_o[gi]),
        .rd_o          (prd[gi])
      );
    end
  endgenerate

  // Pin drive; port 8 bits with function select set carry segments.
  always_comb
  begin
    seg_sel   = port8_pin_function_select_ff & PPFL_P8FN_MASK;
    seg_val   = {2'b00, lcd_segment_output_i};
    pin_out_o = lat;
    pin_oe_o  = oe;
    pin_out_o[PPFL_IX_P8] = (lat[PPFL_IX_P8] & ~seg_sel) |
                            (seg_val & seg_sel);
    pin_oe_o[PPFL_IX_P8]  = oe[PPFL_IX_P8] | seg_sel;
  end

  // Register writes and read data selection.
  always_comb
  begin
    nxt_grouped_port_pullup_select = grouped_port_pullup_select_ff;
    nxt_port2_pin_pullup_select    = port2_pin_pullup_select_ff;
    nxt_port8_pin_function_select  = port8_pin_function_select_ff;
    nxt_rdata                      = rdata_ff;
    if (cpu_wr_i)
    begin
      // Spare bits are not stored and read back as zero.
      unique case (cpu_addr_i)
        PPFL_ADDR_GRPU:
          nxt_grouped_port_pullup_select =
            cpu_wdata_i & PPFL_GRPU_MASK;
        PPFL_ADDR_P2PU:
          nxt_port2_pin_pullup_select =
            cpu_wdata_i & PPFL_P2PU_MASK;
        PPFL_ADDR_P8FN:
          nxt_port8_pin_function_select =
            cpu_wdata_i & PPFL_P8FN_MASK;
        default:
          nxt_rdata = rdata_ff;
      endcase
    end
    if (cpu_rd_i)
    begin
      // Unmapped addresses read as zero.
      nxt_rdata = PPFL_REG_RST;
      unique case (cpu_addr_i)
        PPFL_ADDR_GRPU: nxt_rdata = grouped_port_pullup_select_ff;
        PPFL_ADDR_P2PU: nxt_rdata = port2_pin_pullup_select_ff;
        PPFL_ADDR_P8FN: nxt_rdata = port8_pin_function_select_ff;
        default:
          for (int i = 0; i < PPFL_NPORT; i++)
          begin
            if (cpu_addr_i == PPFL_LATCH_ADDR[i])
            begin
              nxt_rdata = prd[i];
            end
            if (cpu_addr_i == PPFL_MODE_ADDR[i])
            begin
              nxt_rdata = mode_rd[i];
            end
          end
      endcase
    end
  end

  // Registers the control registers and the read data.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      grouped_port_pullup_select_ff <= PPFL_REG_RST;
      port2_pin_pullup_select_ff    <= PPFL_REG_RST;
      port8_pin_function_select_ff  <= PPFL_REG_RST;
      rdata_ff                      <= PPFL_REG_RST;
    end
    else
    begin
      grouped_port_pullup_select_ff <= nxt_grouped_port_pullup_select;
      port2_pin_pullup_select_ff    <= nxt_port2_pin_pullup_select;
      port8_pin_function_select_ff  <= nxt_port8_pin_function_select;
      rdata_ff                      <= nxt_rdata;
    end
  end

  assign cpu_rdata_o = rdata_ff;

  // Checks on the behaviour above.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_PU_INPUT_ONLY: assert property (
    (pu_en_o[PPFL_IX_P4] & pin_oe_o[PPFL_IX_P4]) == 8'h00)
    else $error("Pull-up active on an output bit of port 4.");

  AST_GRPU_WRITE: assert property (
    cpu_wr_i && cpu_addr_i == PPFL_ADDR_GRPU |=>
      grouped_port_pullup_select_ff ==
        ($past(cpu_wdata_i) & PPFL_GRPU_MASK))
    else $error("Grouped pull-up register did not take the write.");

  AST_P2PU_ANY_MODE: assert property (
    cpu_wr_i && cpu_addr_i == PPFL_ADDR_P2PU |=>
      pu_en_o[PPFL_IX_P2] == ($past(cpu_wdata_i) & PPFL_P2PU_MASK))
    else $error("Port 2 pull-up does not follow its select.");

  AST_SEG_DRIVE: assert property (
    (pin_out_o[PPFL_IX_P8] & seg_sel) == (seg_val & seg_sel) &&
    (pin_oe_o[PPFL_IX_P8] & seg_sel) == seg_sel)
    else $error("Selected port 8 pin does not carry its segment.");

  AST_LATCH_HOLD: assert property (
    !(cpu_wr_i && cpu_addr_i == PPFL_LATCH_ADDR[PPFL_IX_P0]) |=>
      $stable(lat[PPFL_IX_P0]))
    else $error("Port 0 latch changed without a write.");

  AST_WRITE_DRIVE: assert property (
    cpu_wr_i && cpu_addr_i == PPFL_LATCH_ADDR[PPFL_IX_P1] |=>
      pin_out_o[PPFL_IX_P1] ==
        ($past(cpu_wdata_i) & PPFL_PIN_MASK[PPFL_IX_P1]))
    else $error("Port 1 pins do not show the written byte.");

  AST_INPUT_FLOATS: assert property (
    (pin_oe_o[PPFL_IX_P0] & mode[PPFL_IX_P0]) == 8'h00)
    else $error("Input-mode bit of port 0 is driven.");

  AST_READ_MUX: assert property (
    cpu_rd_i && cpu_addr_i == PPFL_LATCH_ADDR[PPFL_IX_P2] |=>
      cpu_rdata_o == ((($past(lat[PPFL_IX_P2]) & ~$past(mode[PPFL_IX_P2]))
                    | ($past(pin_i[PPFL_IX_P2]) & $past(mode[PPFL_IX_P2])))
                    & PPFL_PIN_MASK[PPFL_IX_P2]))
    else $error("Port 2 read returned the wrong source.");

endmodule : ppfl_port_ctrl
